// ---- rtl/sfpalu_pkg.sv ----
package sfpalu_pkg;

  // datapath widths
  localparam int WORD_W = 25;
  localparam int EXT_W = 28;
  localparam int ADDR_W = 6;
  localparam int OP_W = 3;
  localparam int SHIFT_W = 4;
  localparam int CONV_W = 9;
  localparam int CONV_SEL_W = 4;
  localparam int CONST_W = 4;
  localparam int STORE_WORDS = 40;

  // address map of the two storage ports
  localparam logic [5:0] CONV_ADDR = 6'h28;
  localparam logic [1:0] CONST_PREFIX = 2'h3;
  localparam logic [15:0] CONV_FILL = 16'hFFFF;

  // operation codes
  localparam logic [2:0] OP_XOR = 3'h0;
  localparam logic [2:0] OP_AND = 3'h1;
  localparam logic [2:0] OP_SIGN_SAT = 3'h2;
  localparam logic [2:0] OP_MAG = 3'h3;
  localparam logic [2:0] OP_MAG_ACC = 3'h4;
  localparam logic [2:0] OP_SUB = 3'h5;
  localparam logic [2:0] OP_ADD = 3'h6;

  // scaler codes
  localparam logic [3:0] SHIFT_L2 = 4'hE;
  localparam logic [3:0] SHIFT_L1 = 4'hD;
  localparam logic [3:0] SHIFT_NONE = 4'hF;

  // extreme legal values
  localparam logic [24:0] NEG_FULL = 25'h1000000;
  localparam logic [24:0] POS_FULL = 25'h0FFFFFF;

  // register byte offsets
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_MEM_INDEX = 8'h10;
  localparam logic [7:0] REG_MEM_DATA = 8'h14;

  // instruction word fields
  localparam int INSTR_OP_LSB = 0;
  localparam int INSTR_SHIFT_LSB = 3;
  localparam int INSTR_ADDR_A_LSB = 7;
  localparam int INSTR_ADDR_B_LSB = 13;
  localparam int INSTR_COND_SEL_LSB = 19;
  localparam int INSTR_COND_EN_BIT = 23;

  // status word fields
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CARRY_BIT = 1;
  localparam int STAT_CONV_LSB = 16;

  // reset values
  localparam logic [31:0] INSTR_RESET = 32'h00000000;
  localparam logic CTRL_LIMIT_RESET = 1'b0;

endpackage

// ---- rtl/sfpalu_core.sv ----
// Function
// - flag overflow outside minus one to one
// - limiting writes nearest full-scale value
// - open-drain low overflow pin, previous instruction
// - unlimited: 28-bit math, keep low 25
// - magnitude ops take source magnitude first
// - load and magnitude are add to zero
// - sign-saturate writes full scale by sign
// - sign-saturate overflow as equivalent load
// - constants pass through the scaler too
// - conditional execution on converter bit
// - conditional subtract uses and stores carry
// - result is 25-bit two's complement
// - source 28 bits, destination widened to 28
// - instruction carries op, shift, two addresses
// - constant source: four bits high, zeros below
// - left fills zeros, right fills sign
// - operation field encoding
// - result written at instruction end
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module sfpalu_core #(
  parameter int DEPTH = 40
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // overflow pin, open drain
  output logic overflow_out_n_o,
  output logic overflow_out_n_oe,
  // converter register to the d/a side
  output logic [sfpalu_pkg::CONV_W-1:0] converter_register
);
  import sfpalu_pkg::*;

  // refuse a storage depth outside 1..40, so storage never reaches the converter address 40
  if (DEPTH < 1 || DEPTH > STORE_WORDS)
  begin : g_bad_depth
    $error("DEPTH must lie in 1..40");
  end

  ////////////////////////////////////////////////////////////////////
  // helpers

  // arithmetic barrel scaler on the sign-extended source
  function automatic logic [EXT_W-1:0] scale(input logic [WORD_W-1:0] v,
                                            input logic [SHIFT_W-1:0] code);
    logic signed [EXT_W-1:0] ext;
    ext = EXT_W'(signed'(v));
    case (code)
      SHIFT_L2: scale = ext <<< 2;
      SHIFT_L1: scale = ext <<< 1;
      SHIFT_NONE: scale = ext;
      default: scale = ext >>> (code + 4'h1);
    endcase
  endfunction

  function automatic logic out_of_range(input logic [EXT_W-1:0] v);
    out_of_range = (v[EXT_W-1:WORD_W-1] != {(EXT_W-WORD_W+1){v[WORD_W-1]}});
  endfunction

  function automatic logic [WORD_W-1:0] full_scale(input logic negative);
    full_scale = negative ? NEG_FULL : POS_FULL;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus front end: every transfer gets one wait state

  logic take;
  logic d_act;
  logic d_write;
  logic [7:0] d_addr;
  logic wait_edge;

  assign take = hsel && hready && htrans[1];
  assign wait_edge = d_act && !hreadyout;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      d_act <= 1'b0;
      d_write <= 1'b0;
      d_addr <= 8'h00;
    end
    else if (take)
    begin
      d_act <= 1'b1;
      d_write <= hwrite;
      d_addr <= haddr[7:0];
    end
    else if (hreadyout)
      d_act <= 1'b0;
  end

  // one wait cycle lets a pending instruction retire before any read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout <= 1'b1;
    else
      hreadyout <= !take;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // software registers

  logic [31:0] instr;
  logic limit_en;
  logic exec_go;
  logic [5:0] mem_index;
  logic bus_mem_we;

  assign bus_mem_we = wait_edge && d_write && d_addr == REG_MEM_DATA
                      && mem_index < 6'(DEPTH);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr <= INSTR_RESET;
      limit_en <= CTRL_LIMIT_RESET;
      mem_index <= 6'h00;
    end
    else if (wait_edge && d_write)
    begin
      case (d_addr)
        REG_INSTR: instr <= hwdata;
        REG_CTRL: limit_en <= hwdata[0];
        REG_MEM_INDEX: mem_index <= hwdata[5:0];
        default: ;
      endcase
    end
  end

  // instruction runs in the cycle after its write is captured
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      exec_go <= 1'b0;
    else
      exec_go <= wait_edge && d_write && d_addr == REG_INSTR;
  end

  ////////////////////////////////////////////////////////////////////
  // instruction decode

  logic [OP_W-1:0] op;
  logic [SHIFT_W-1:0] shift_code;
  logic [ADDR_W-1:0] addr_a;
  logic [ADDR_W-1:0] addr_b;
  logic [CONV_SEL_W-1:0] cond_sel;
  logic cond_en;

  assign op = instr[INSTR_OP_LSB +: OP_W];
  assign shift_code = instr[INSTR_SHIFT_LSB +: SHIFT_W];
  assign addr_a = instr[INSTR_ADDR_A_LSB +: ADDR_W];
  assign addr_b = instr[INSTR_ADDR_B_LSB +: ADDR_W];
  assign cond_sel = instr[INSTR_COND_SEL_LSB +: CONV_SEL_W];
  assign cond_en = instr[INSTR_COND_EN_BIT];

  ////////////////////////////////////////////////////////////////////
  // storage and operand ports

  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] src_word;
  logic [WORD_W-1:0] dst_word;
  logic [WORD_W-1:0] conv_word;

  assign conv_word = {converter_register, CONV_FILL};

  always_comb
  begin
    if (addr_a[5:4] == CONST_PREFIX)
      src_word = {addr_a[CONST_W-1:0], 21'h000000};
    else if (addr_a == CONV_ADDR)
      src_word = conv_word;
    else if (addr_a < 6'(DEPTH))
      src_word = mem[addr_a];
    else
      src_word = '0;
  end

  always_comb
  begin
    if (addr_b == CONV_ADDR)
      dst_word = conv_word;
    else if (addr_b < 6'(DEPTH))
      dst_word = mem[addr_b];
    else
      dst_word = '0;
  end

  ////////////////////////////////////////////////////////////////////
  // arithmetic

  logic [EXT_W-1:0] a_scaled;
  logic [EXT_W-1:0] a_mag;
  logic [EXT_W-1:0] b_ext;
  logic [EXT_W-1:0] load_sum;
  logic [EXT_W:0] raw;
  logic [EXT_W-1:0] wide;
  logic arith;
  logic raw_ovf;
  logic next_ovf;
  logic next_carry;
  logic [WORD_W-1:0] next_result;
  logic carry_flag;
  logic overflow_flag;
  logic [WORD_W-1:0] result_reg;
  logic cond_ok;
  logic do_write;

  assign a_scaled = scale(src_word, shift_code);
  assign a_mag = a_scaled[EXT_W-1] ? EXT_W'(-a_scaled) : a_scaled;
  assign b_ext = EXT_W'(signed'(dst_word));
  assign load_sum = a_scaled;

  always_comb
  begin
    arith = 1'b1;
    raw = '0;
    case (op)
      OP_XOR:
      begin
        arith = 1'b0;
        raw = {1'b0, b_ext ^ a_scaled};
      end
      OP_AND:
      begin
        arith = 1'b0;
        raw = {1'b0, b_ext & a_scaled};
      end
      OP_SIGN_SAT: raw = {1'b0, load_sum};
      OP_MAG: raw = {1'b0, a_mag};
      OP_MAG_ACC: raw = {1'b0, b_ext} + {1'b0, a_mag};
      OP_SUB: raw = {1'b0, b_ext} + {1'b0, ~a_scaled} + 29'h1;
      OP_ADD: raw = {1'b0, b_ext} + {1'b0, a_scaled};
      default: arith = 1'b0;
    endcase
  end

  assign wide = raw[EXT_W-1:0];
  assign raw_ovf = arith && out_of_range(wide);
  assign next_carry = raw[EXT_W];

  always_comb
  begin
    if (op == OP_SIGN_SAT)
      next_result = full_scale(a_scaled[EXT_W-1]);
    else if (raw_ovf && limit_en)
      next_result = full_scale(wide[EXT_W-1]);
    else
      next_result = wide[WORD_W-1:0];
  end

  // conditional subtract tests the previous carry, others a converter bit
  always_comb
  begin
    if (!cond_en)
      cond_ok = 1'b1;
    else if (op == OP_SUB)
      cond_ok = carry_flag;
    else if (cond_sel < 4'(CONV_W))
      cond_ok = converter_register[cond_sel];
    else
      cond_ok = 1'b0;
  end

  assign do_write = exec_go && cond_ok && op != 3'h7;
  assign next_ovf = do_write && raw_ovf;

  ////////////////////////////////////////////////////////////////////
  // write back at the end of the instruction cycle

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else if (do_write && addr_b < 6'(DEPTH))
      mem[addr_b] <= next_result;
    else if (bus_mem_we)
      mem[mem_index] <= hwdata[WORD_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      converter_register <= '0;
    else if (exec_go)
    begin
      // carry store lands after a result write to the same register
      if (do_write && addr_b == CONV_ADDR)
        converter_register <= next_result[WORD_W-1 -: CONV_W];
      if (cond_en && op == OP_SUB && cond_sel < 4'(CONV_W))
        converter_register[cond_sel] <= next_carry;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      overflow_flag <= 1'b0;
      carry_flag <= 1'b0;
      result_reg <= '0;
    end
    else if (exec_go)
    begin
      overflow_flag <= next_ovf;
      if (do_write)
      begin
        carry_flag <= next_carry;
        result_reg <= next_result;
      end
    end
  end

  // pin only ever pulls low; released means no overflow
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      overflow_out_n_o <= 1'b0;
      overflow_out_n_oe <= 1'b0;
    end
    else
    begin
      overflow_out_n_o <= 1'b0;
      if (exec_go)
        overflow_out_n_oe <= next_ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data, loaded at the end of the wait cycle

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (wait_edge && !d_write)
    begin
      case (d_addr)
        REG_INSTR: hrdata <= instr;
        REG_CTRL: hrdata <= {31'h00000000, limit_en};
        REG_STATUS:
        begin
          hrdata <= 32'h00000000;
          hrdata[STAT_OVF_BIT] <= overflow_flag;
          hrdata[STAT_CARRY_BIT] <= carry_flag;
          hrdata[STAT_CONV_LSB +: CONV_W] <= converter_register;
        end
        REG_RESULT: hrdata <= {7'h00, result_reg};
        REG_MEM_INDEX: hrdata <= {26'h0000000, mem_index};
        REG_MEM_DATA: hrdata <= (mem_index < 6'(DEPTH)) ? {7'h00, mem[mem_index]} : 32'h00000000;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- verif/sfpalu_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfpalu_props (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic overflow_out_n_o,
  input wire logic overflow_out_n_oe,
  input wire logic [sfpalu_pkg::CONV_W-1:0] converter_register
);
  import sfpalu_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic tk;
  logic ex;
  logic st;
  assign tk = hsel & hready & htrans[1];
  assign ex = tk & hwrite & (haddr[7:0] == REG_INSTR);
  assign st = tk & !hwrite & (haddr[7:0] == REG_STATUS);
  ////////////////////////////////
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_wait;
    tk |=> s_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("wait cycle wrong");
  property p_idle;
    hreadyout && !tk |=> hreadyout;
  endproperty
  a_idle: assert property (p_idle) else $error("ready dropped");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_drain;
    overflow_out_n_o == 1'b0;
  endproperty
  a_drain: assert property (p_drain) else $error("pin driven high");
  // flags move only three edges after an instruction write is taken
  property p_oe;
    !$stable(overflow_out_n_oe) |-> $past(ex, 3);
  endproperty
  a_oe: assert property (p_oe) else $error("overflow moved alone");
  property p_conv;
    !$stable(converter_register) |-> $past(ex, 3);
  endproperty
  a_conv: assert property (p_conv) else $error("converter moved alone");
  property p_sovf;
    st |-> ##2 (hrdata[0] == overflow_out_n_oe);
  endproperty
  a_sovf: assert property (p_sovf) else $error("status overflow bit");
  property p_sconv;
    st |-> ##2 (hrdata[24:16] == converter_register);
  endproperty
  a_sconv: assert property (p_sconv) else $error("status converter");
endmodule
bind sfpalu_core sfpalu_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .overflow_out_n_o(overflow_out_n_o),
  .overflow_out_n_oe(overflow_out_n_oe), .converter_register(converter_register)
);
`default_nettype wire

// ---- verif/sfpalu_prog.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfpalu_prog (
  // answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  ////////////////////////////////
  // random idle gap so the slave sees both paced and dense traffic
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    repeat ($urandom % 3) @(posedge hclk);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfpalu_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic ovf_o;
  logic ovf_oe;
  logic ovf_pin_n;
  logic [CONV_W-1:0] conv;
  logic [31:0] q;
  logic [5:0] sa;
  int n_fail = 0;
  int checked = 0;
  always #12.5 hclk = ~hclk;
  // pull-up on the open-drain line
  assign ovf_pin_n = ovf_oe ? ovf_o : 1'b1;
  sfpalu_core u_sfpalu_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .overflow_out_n_o(ovf_o),
    .overflow_out_n_oe(ovf_oe), .converter_register(conv)
  );
  sfpalu_prog u_prog (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );
  ////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_prog.xfer(1'b1, a, d, r);
  endtask
  // 28-bit working width keeps left-shift overflow visible
  function automatic logic [25:0] ref_alu(input logic [2:0] op, input logic [3:0] sh,
      input logic [24:0] a, input logic [24:0] b, input logic sign_saturate_op);
    logic signed [27:0] x;
    logic signed [27:0] y;
    logic v;
    x = {{3{a[24]}}, a};
    y = {{3{b[24]}}, b};
    if (sh == SHIFT_L2) x = x <<< 2;
    else if (sh == SHIFT_L1) x = x <<< 1;
    else if (sh != SHIFT_NONE) x = x >>> (sh + 4'h1);
    if (op == OP_MAG || op == OP_MAG_ACC) x = x[27] ? -x : x;
    case (op)
      OP_XOR: y = y ^ x;
      OP_AND: y = y & x;
      OP_SUB: y = y - x;
      OP_ADD, OP_MAG_ACC: y = y + x;
      default: y = x;
    endcase
    v = op > OP_AND && (y < -28'sh1000000 || y > 28'sh0FFFFFF);
    if (op == OP_SIGN_SAT) y = a[24] ? NEG_FULL : POS_FULL;
    else if (v && sign_saturate_op) y = y[27] ? NEG_FULL : POS_FULL;
    return {v, y[24:0]};
  endfunction
  // run one instruction; dest 40 is the converter, run low means skipped
  task automatic exec(input logic [2:0] op, input logic [3:0] sh, input logic [5:0] s,
      input logic [5:0] d, input logic [24:0] a, input logic [24:0] b, input logic sign_saturate_op,
      input logic [4:0] cnd, input logic run);
    logic [25:0] e;
    e = ref_alu(op, sh, s >= 48 ? {s[3:0], 21'h0} : a, b, sign_saturate_op);
    if (!run) e = {1'b0, b};
    if (d < 40) wr(REG_MEM_INDEX, 32'(d));
    if (d < 40) wr(REG_MEM_DATA, 32'(b));
    if (s < 40) wr(REG_MEM_INDEX, 32'(s));
    if (s < 40) wr(REG_MEM_DATA, 32'(a));
    wr(REG_CTRL, 32'(sign_saturate_op));
    wr(REG_INSTR, {8'h0, cnd, d, s, sh, op});
    u_prog.xfer(1'b0, REG_STATUS, 32'h0, q);
    chk(32'(q[0]), 32'(e[25]));
    chk(32'(ovf_pin_n), 32'(!e[25]));
    if (d < 40) wr(REG_MEM_INDEX, 32'(d));
    if (d < 40) u_prog.xfer(1'b0, REG_MEM_DATA, 32'h0, q);
    if (d < 40) chk(q, 32'(e[24:0]));
    else chk(32'(conv), 32'(e[24:16]));
  endtask
  ////////////////////////////////
  initial
  begin
    void'($urandom(97));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    u_prog.xfer(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h0);
    u_prog.xfer(1'b0, 8'h1C, 32'h0, q);
    chk(q, 32'h0);
    exec(OP_ADD, SHIFT_L2, 6'd5, 6'd6, 25'h0C00000, '0, 1'b1, 5'h0, 1'b1);
    exec(OP_ADD, SHIFT_L2, 6'd5, 6'd6, 25'h0C00000, '0, 1'b0, 5'h0, 1'b1);
    exec(OP_SIGN_SAT, SHIFT_L2, 6'd5, 6'd6, 25'h0C00000, 25'h1, 1'b0, 5'h0, 1'b1);
    exec(OP_MAG, SHIFT_NONE, 6'd56, 6'd6, '0, 25'h5, 1'b1, 5'h0, 1'b1);
    exec(OP_MAG_ACC, 4'hC, 6'd56, 6'd7, '0, 25'h5, 1'b0, 5'h0, 1'b1);
    exec(OP_ADD, SHIFT_NONE, 6'd63, 6'd40, '0, 25'h000FFFF, 1'b0, 5'h0, 1'b1);
    exec(OP_ADD, SHIFT_L1, 6'd52, 6'd3, '0, 25'h0C00000, 1'b0, 5'h18, 1'b1);
    exec(OP_ADD, SHIFT_L1, 6'd52, 6'd3, '0, 25'h0C00000, 1'b0, 5'h10, 1'b0);
    // 3 minus 1 carries out; the conditional one then runs and stores its own carry in bit 2
    exec(OP_SUB, SHIFT_NONE, 6'd1, 6'd2, 25'h1, 25'h3, 1'b0, 5'h0, 1'b1);
    exec(OP_SUB, SHIFT_NONE, 6'd1, 6'd2, 25'h1, 25'h3, 1'b0, 5'h12, 1'b1);
    chk(32'(conv[2]), 32'h1);
    for (int i = 0; i < 60; i++)
    begin
      sa = ($urandom % 2) ? 6'(48 + $urandom % 16) : 6'($urandom % 40);
      exec(3'($urandom % 7), 4'($urandom), sa, 6'((sa + 1) % 40), 25'($urandom),
        25'($urandom), 1'($urandom), 5'h0, 1'b1);
    end
    wrap_up;
  end
  initial
  begin
    #(25 * 40000);
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
